// ### rtl/mie_pkg.sv
package mie_pkg;

	// ****************************************
	// Widths and special register addresses
	// ****************************************
	localparam int PC_W = 13;
	localparam int RA_W = 6;
	localparam int RF_DEPTH = 64;
	localparam int STK_DEPTH = 8;
	localparam int STK_PTR_W = 3;
	localparam int INSN_W = 15;
	localparam logic [5:0] ADR_PC = 6'h02;
	localparam logic [5:0] ADR_STATUS = 6'h03;
	localparam logic [5:0] ADR_TPL = 6'h04;
	localparam logic [5:0] ADR_TPH = 6'h05;
	localparam logic [5:0] ADR_IO = 6'h06;

	// ****************************************
	// Reset values and timing
	// ****************************************
	localparam logic [PC_W-1:0] PC_RST = 13'h0000;
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [STK_PTR_W-1:0] SP_RST = 3'h0;
	// Oscillator periods per instruction cycle
	localparam int OSC_PER_CYCLE = 2;
	localparam logic PHASE_LAST = 1'(OSC_PER_CYCLE - 1);

	// ****************************************
	// Operation codes, bits 14..10 of a word
	// ****************************************
	typedef enum logic [4:0] {
		OP_NOP = 5'h00, OP_RESET = 5'h01, OP_TABLE_WRITE_START = 5'h02,
		OP_TABLE_READ_TO_BOTH = 5'h03, OP_MOVRA = 5'h04, OP_MOVAR = 5'h05,
		OP_ADD = 5'h06, OP_SUB = 5'h07, OP_AND = 5'h08,
		OP_OR = 5'h09, OP_XOR = 5'h0A, OP_CLR = 5'h0B,
		OP_NEG = 5'h0C, OP_BC = 5'h0D, OP_BS = 5'h0E,
		OP_JBC = 5'h0F, OP_JBS = 5'h10, OP_JER = 5'h11,
		OP_JGER = 5'h12, OP_JLER = 5'h13, OP_JEK = 5'h14,
		OP_MOVAK = 5'h15, OP_ADDAK = 5'h16, OP_SJC = 5'h17,
		OP_SHORT_JUMP_IF_NO_CARRY = 5'h18, OP_SJZ = 5'h19, OP_SHORT_JUMP_IF_NOT_ZERO = 5'h1A,
		OP_LONG_CALL = 5'h1B, OP_LONG_JUMP = 5'h1C, OP_JMP = 5'h1D,
		OP_RET = 5'h1E
	} mie_op_t;

	// Instruction word layout
	typedef struct packed {
		mie_op_t op;
		logic dest;
		logic [2:0] bitsel;
		logic [RA_W-1:0] ra;
	} mie_insn_t;

	// Status flags, low five bits of the status register
	typedef struct packed {
		logic n;
		logic ov;
		logic dc;
		logic c;
		logic z;
	} mie_flags_t;

	typedef struct packed {
		logic [7:0] res;
		logic c;
		logic dc;
		logic ov;
	} mie_alu_t;

	// Sequencer states, Gray coded along run, flush, table
	typedef enum logic [1:0] {
		ST_RUN = 2'b00,
		ST_FLUSH = 2'b01,
		ST_TABLE = 2'b11
	} mie_state_t;

	// Adder with carry in, shared by add, subtract and negate
	function automatic mie_alu_t alu_add(input logic [7:0] x,
		input logic [7:0] y, input logic cin);
		logic [8:0] s;
		logic [4:0] h;
		mie_alu_t r;
		s = {1'b0, x} + {1'b0, y} + {8'h00, cin};
		h = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, cin};
		r.res = s[7:0];
		r.c = s[8];
		r.dc = h[4];
		r.ov = (x[7] == y[7]) && (s[7] != x[7]);
		return r;
	endfunction

	// Addresses served by core logic rather than the memory
	function automatic logic is_special(input logic [RA_W-1:0] a);
		return (a >= ADR_PC) && (a <= ADR_IO);
	endfunction

endpackage

// ### rtl/mie_mem.sv
`timescale 1ns/1ns
module mie_mem #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 64,
	parameter int AW = 6
) (
	// Clock
	input wire logic clk,
	// Write port
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [WIDTH-1:0] wdata,
	// Read port, data registered
	input wire logic [AW-1:0] raddr,
	output logic [WIDTH-1:0] rdata_r
);

	logic [WIDTH-1:0] mem [DEPTH];

	// Contents carry no reset; read lags address by one clock
	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata_r <= mem[raddr];
	end

endmodule

// ### rtl/mie_core.sv
`timescale 1ns/1ns
// Function
// - decode 15-bit word, opcode plus operands
// - ordinary instruction takes one two-clock cycle
// - writing program counter register costs two cycles
// - long call, long jump, taken skips: two cycles
// - set, clear, test any single register bit
// - port register reads return the pins, writes go to the output latch
// - literals are 8 or 10 bits
// - software reset restores all reset values
// - table write start leaves flags alone
// - table read: low byte to A, high to R
// - compare with accumulator, skip, flags untouched
// - short jumps reach +127 to -128 words
// - long targets from next word; call pushes first
// - negate is inverse plus one, five flags
module mie_core import mie_pkg::*; (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Program flash
	output logic [PC_W-1:0] prog_addr_r,
	input wire logic [INSN_W-1:0] prog_rdata,
	// Table write request
	output logic tbl_wr_start_r,
	output logic [PC_W-1:0] tbl_wr_addr_r,
	output logic [7:0] tbl_wr_data_r,
	// Port register
	input wire logic [7:0] io_in,
	output logic [7:0] io_out_r
);

	// ****************************************
	// State
	// ****************************************
	logic srst;
	logic soft_rst_r;
	logic phase_r;
	logic ce;
	mie_state_t state_r;
	mie_insn_t ir_r;
	logic [PC_W-1:0] pc_r;
	logic [PC_W-1:0] cur_r;
	logic [7:0] acc_r;
	mie_flags_t flags_r;
	logic [PC_W-1:0] tp_r;
	logic [STK_PTR_W-1:0] sp_r;
	logic [RA_W-1:0] tbl_reg_r;
	logic [7:0] rf_rdata;
	logic [PC_W-1:0] stk_rdata;
	logic exec;

	// Decode and execute results
	logic [7:0] rval;
	logic [7:0] k8;
	logic [7:0] res;
	logic [7:0] bmask;
	mie_alu_t s;
	mie_flags_t fl_nxt;
	logic wr_r;
	logic wr_a;
	logic skip;
	logic jump;
	logic push;
	logic pop;
	logic do_tbr;
	logic do_tbw;
	logic do_rst;
	logic [PC_W-1:0] tgt;
	logic wr_en;
	logic [RA_W-1:0] wr_addr;
	logic [7:0] wr_data;
	logic redirect;
	logic [PC_W-1:0] pc_nxt;

	// Software reset shares the synchronous reset path
	assign srst = !rst_n || soft_rst_r;
	assign ce = (phase_r == PHASE_LAST);
	assign exec = ce && (state_r == ST_RUN);
	assign k8 = {ir_r.bitsel[1:0], ir_r.ra};
	assign bmask = 8'h01 << ir_r.bitsel;

	// ****************************************
	// Memories
	// ****************************************
	mie_mem #(.WIDTH(8), .DEPTH(RF_DEPTH), .AW(RA_W)) u_rf (
		.clk(core_clk),
		.we(wr_en && !is_special(wr_addr)),
		.waddr(wr_addr),
		.wdata(wr_data),
		.raddr(ir_r.ra),
		.rdata_r(rf_rdata)
	);

	mie_mem #(.WIDTH(PC_W), .DEPTH(STK_DEPTH), .AW(STK_PTR_W)) u_stk (
		.clk(core_clk),
		.we(exec && push),
		.waddr(sp_r),
		.wdata(pc_r + 13'h0001),
		.raddr(sp_r - 3'h1),
		.rdata_r(stk_rdata)
	);

	// ****************************************
	// Operand read
	// ****************************************
	// Specials and the port read like any other register
	always_comb begin
		case (ir_r.ra)
			ADR_PC: rval = cur_r[7:0];
			ADR_STATUS: rval = {3'h0, flags_r};
			ADR_TPL: rval = tp_r[7:0];
			ADR_TPH: rval = {3'h0, tp_r[12:8]};
			ADR_IO: rval = io_in;
			default: rval = rf_rdata;
		endcase
	end

	// ****************************************
	// Execute
	// ****************************************
	// One decode per cycle, word split by field layout
	always_comb begin
		s = alu_add(acc_r, rval, 1'b0);
		res = BYTE_RST;
		fl_nxt = flags_r;
		wr_r = 1'b0;
		wr_a = 1'b0;
		skip = 1'b0;
		jump = 1'b0;
		push = 1'b0;
		pop = 1'b0;
		do_tbr = 1'b0;
		do_tbw = 1'b0;
		do_rst = 1'b0;
		tgt = pc_r;
		case (ir_r.op)
			OP_RESET: do_rst = 1'b1;
			OP_TABLE_WRITE_START: do_tbw = 1'b1;
			OP_TABLE_READ_TO_BOTH: do_tbr = 1'b1;
			OP_MOVRA: begin
				res = acc_r;
				wr_r = 1'b1;
			end
			OP_MOVAR: begin
				res = rval;
				wr_a = 1'b1;
				fl_nxt.z = (rval == 8'h00);
			end
			OP_ADD, OP_SUB, OP_ADDAK, OP_NEG: begin
				if (ir_r.op == OP_SUB) begin
					s = alu_add(rval, ~acc_r, 1'b1);
				end else if (ir_r.op == OP_ADDAK) begin
					s = alu_add(acc_r, k8, 1'b0);
				end else if (ir_r.op == OP_NEG) begin
					s = alu_add(~rval, 8'h00, 1'b1);
				end
				res = s.res;
				fl_nxt = '{n: s.res[7], ov: s.ov, dc: s.dc, c: s.c,
					z: (s.res == 8'h00)};
				wr_r = (ir_r.op == OP_NEG) ||
					(ir_r.op != OP_ADDAK && ir_r.dest);
				wr_a = !wr_r;
			end
			OP_AND, OP_OR, OP_XOR: begin
				if (ir_r.op == OP_AND) begin
					res = acc_r & rval;
				end else if (ir_r.op == OP_OR) begin
					res = acc_r | rval;
				end else begin
					res = acc_r ^ rval;
				end
				fl_nxt.z = (res == 8'h00);
				fl_nxt.n = res[7];
				wr_r = ir_r.dest;
				wr_a = !ir_r.dest;
			end
			OP_CLR: begin
				wr_r = 1'b1;
				fl_nxt.z = 1'b1;
			end
			OP_BC: begin
				res = rval & ~bmask;
				wr_r = 1'b1;
			end
			OP_BS: begin
				res = rval | bmask;
				wr_r = 1'b1;
			end
			OP_JBC: skip = ((rval & bmask) == 8'h00);
			OP_JBS: skip = ((rval & bmask) != 8'h00);
			OP_JER: skip = (rval == acc_r);
			OP_JGER: skip = (rval > acc_r);
			OP_JLER: skip = (rval < acc_r);
			OP_JEK: skip = (k8 == acc_r);
			OP_MOVAK: begin
				res = k8;
				wr_a = 1'b1;
			end
			OP_SJC, OP_SHORT_JUMP_IF_NO_CARRY, OP_SJZ, OP_SHORT_JUMP_IF_NOT_ZERO: begin
				// Signed 8-bit offset bounds the reach by itself
				tgt = cur_r + {{5{k8[7]}}, k8};
				case (ir_r.op)
					OP_SJC: jump = flags_r.c;
					OP_SHORT_JUMP_IF_NO_CARRY: jump = !flags_r.c;
					OP_SJZ: jump = flags_r.z;
					default: jump = !flags_r.z;
				endcase
			end
			OP_LONG_CALL, OP_LONG_JUMP: begin
				// Second word is on the flash bus right now
				tgt = prog_rdata[PC_W-1:0];
				push = (ir_r.op == OP_LONG_CALL);
				jump = 1'b1;
			end
			OP_JMP: begin
				tgt = {cur_r[12:10], ir_r.dest, ir_r.bitsel,
					ir_r.ra};
				jump = 1'b1;
			end
			OP_RET: begin
				tgt = stk_rdata;
				pop = 1'b1;
				jump = 1'b1;
			end
			default: ;
		endcase
		// A register write aimed at the program counter
		if (wr_r && ir_r.ra == ADR_PC) begin
			tgt = {cur_r[12:8], res};
			jump = 1'b1;
		end
	end

	// Shared register write path: execute or table read
	always_comb begin
		wr_en = 1'b0;
		wr_addr = ir_r.ra;
		wr_data = res;
		if (ce && state_r == ST_TABLE) begin
			wr_en = 1'b1;
			wr_addr = tbl_reg_r;
			wr_data = {1'b0, prog_rdata[14:8]};
		end else if (exec && wr_r) begin
			wr_en = 1'b1;
		end
	end

	assign redirect = exec && (jump || skip);
	assign pc_nxt = (exec && jump) ? tgt : pc_r + 13'h0001;

	// ****************************************
	// Sequencer
	// ****************************************
	// Divider: phase 1 closes each instruction cycle
	always_ff @(posedge core_clk) begin
		if (srst) begin
			phase_r <= 1'b0;
		end else begin
			phase_r <= !phase_r;
		end
	end

	// Fetch, flush and table cycles
	always_ff @(posedge core_clk) begin
		if (srst) begin
			state_r <= ST_FLUSH;
			ir_r <= '{op: OP_NOP, dest: 1'b0, bitsel: 3'h0, ra: 6'h00};
			pc_r <= PC_RST;
			cur_r <= PC_RST;
			prog_addr_r <= PC_RST;
			tbl_reg_r <= 6'h00;
		end else if (ce && state_r == ST_TABLE) begin
			// Next word already held in ir; fetch resumes after it
			state_r <= ST_RUN;
			prog_addr_r <= pc_r;
		end else if (ce) begin
			// Word fetched on a redirect is dropped; the flush cycle loads the target
			ir_r <= mie_insn_t'(prog_rdata);
			cur_r <= pc_r;
			pc_r <= pc_nxt;
			prog_addr_r <= (exec && do_tbr) ? tp_r : pc_nxt;
			tbl_reg_r <= ir_r.ra;
			if (redirect) begin
				state_r <= ST_FLUSH;
			end else if (exec && do_tbr) begin
				state_r <= ST_TABLE;
			end else begin
				state_r <= ST_RUN;
			end
		end
	end

	// Accumulator
	always_ff @(posedge core_clk) begin
		if (srst) begin
			acc_r <= BYTE_RST;
		end else if (ce && state_r == ST_TABLE) begin
			acc_r <= prog_rdata[7:0];
		end else if (exec && wr_a) begin
			acc_r <= res;
		end
	end

	// Flags: an explicit status write beats the op's update
	always_ff @(posedge core_clk) begin
		if (srst) begin
			flags_r <= '0;
		end else if (wr_en && wr_addr == ADR_STATUS) begin
			flags_r <= wr_data[4:0];
		end else if (exec) begin
			flags_r <= fl_nxt;
		end
	end

	// Table pointer and port register
	always_ff @(posedge core_clk) begin
		if (srst) begin
			tp_r <= PC_RST;
			io_out_r <= BYTE_RST;
		end else if (wr_en) begin
			if (wr_addr == ADR_TPL) begin
				tp_r[7:0] <= wr_data;
			end
			if (wr_addr == ADR_TPH) begin
				tp_r[12:8] <= wr_data[4:0];
			end
			if (wr_addr == ADR_IO) begin
				io_out_r <= wr_data;
			end
		end
	end

	// Stack pointer wraps over eight levels
	always_ff @(posedge core_clk) begin
		if (srst) begin
			sp_r <= SP_RST;
		end else if (exec && push) begin
			sp_r <= sp_r + 3'h1;
		end else if (exec && pop) begin
			sp_r <= sp_r - 3'h1;
		end
	end

	// Table write request and software reset
	always_ff @(posedge core_clk) begin
		if (srst) begin
			tbl_wr_start_r <= 1'b0;
			tbl_wr_addr_r <= PC_RST;
			tbl_wr_data_r <= BYTE_RST;
			soft_rst_r <= 1'b0;
		end else begin
			tbl_wr_start_r <= exec && do_tbw;
			if (exec && do_tbw) begin
				tbl_wr_addr_r <= tp_r;
				tbl_wr_data_r <= acc_r;
			end
			soft_rst_r <= exec && do_rst;
		end
	end

endmodule

// ### tb/mie_core_sva.sv
`timescale 1ns/1ns
// ********
// Port checker
// ********
module mie_core_sva import mie_pkg::*; (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Flash link
	input wire logic [PC_W-1:0] prog_addr_r,
	input wire logic [INSN_W-1:0] prog_rdata,
	// Table write
	input wire logic tbl_wr_start_r,
	input wire logic [PC_W-1:0] tbl_wr_addr_r,
	input wire logic [7:0] tbl_wr_data_r,
	// Port register
	input wire logic [7:0] io_in,
	input wire logic [7:0] io_out_r
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// Flush cycle at address zero, then the first step
	sequence s_boot;
		prog_addr_r == PC_RST ##[1:2] prog_addr_r == 13'h0001;
	endsequence
	sequence s_clean;
		prog_addr_r == PC_RST && io_out_r == BYTE_RST && !tbl_wr_start_r;
	endsequence
	a_reset_vals: assert property ($rose(rst_n) |-> s_clean)
		else $error("outputs not at reset values");
	a_boot_fetch: assert property ($rose(rst_n) |-> s_boot)
		else $error("first fetch out of order");
	// Software reset may move the address right after a cycle end
	a_addr_stands: assert property ($changed(prog_addr_r) |=>
		$stable(prog_addr_r) || prog_addr_r == PC_RST)
		else $error("address held under two clocks");
	a_start_pulse: assert property (tbl_wr_start_r |=>
		!tbl_wr_start_r) else $error("start wider than a clock");
	a_start_edge: assert property ($rose(tbl_wr_start_r) |->
		$changed(prog_addr_r)) else $error("start off cycle end");
	a_tbl_hold: assert property (!tbl_wr_start_r &&
		(tbl_wr_addr_r != PC_RST || tbl_wr_data_r != BYTE_RST) |->
		$stable(tbl_wr_addr_r) && $stable(tbl_wr_data_r))
		else $error("table write fields moved");
	a_io_edge: assert property ($changed(io_out_r) |->
		$changed(prog_addr_r)) else $error("port moved off cycle end");
	a_io_hold: assert property ($changed(io_out_r) |=>
		$stable(io_out_r) || io_out_r == BYTE_RST)
		else $error("port changed twice in a cycle");
endmodule
bind mie_core mie_core_sva u_mie_core_sva (.core_clk(core_clk),
	.rst_n(rst_n), .prog_addr_r(prog_addr_r), .prog_rdata(prog_rdata),
	.tbl_wr_start_r(tbl_wr_start_r), .tbl_wr_addr_r(tbl_wr_addr_r),
	.tbl_wr_data_r(tbl_wr_data_r), .io_in(io_in), .io_out_r(io_out_r));

// ### tb/mie_flash_model.sv
`timescale 1ns/1ns
// ********
// Program flash
// ********
module mie_flash_model import mie_pkg::*; (
	// Word address and data
	input wire logic [PC_W-1:0] addr,
	output logic [INSN_W-1:0] rdata
);
	logic [INSN_W-1:0] mem [0:8191];
	// Blank words read as no-op so flushed fetches stay known
	initial foreach (mem[j]) mem[j] = '0;
	// No wait states: data settles long before the cycle end
	assign rdata = mem[addr];
endmodule

// ### tb/testbench.sv
`timescale 1ns/1ns
// ********
// Core bench
// ********
module testbench;
	import mie_pkg::*;
	logic core_clk, rst_n, tbl_wr_start_r, sk;
	logic [PC_W-1:0] prog_addr_r, tbl_wr_addr_r, tp;
	logic [INSN_W-1:0] prog_rdata, tw;
	logic [7:0] tbl_wr_data_r, io_in, io_out_r, x, nx, y, k, io, a;
	logic [8:0] s;
	logic [2:0] b;
	logic [23:0] ed[$], ei[$];
	int eg[$];
	int n_mismatch, checks_done, clk_n, last_t, pc, cyc, rp, it, i, t, g;
	mie_op_t cop[4] = '{OP_JGER, OP_JER, OP_JLER, OP_JEK};
	mie_op_t jop[4] = '{OP_SJC, OP_SHORT_JUMP_IF_NO_CARRY, OP_SJZ, OP_SHORT_JUMP_IF_NOT_ZERO};
	mie_core u_mie_core (.core_clk(core_clk), .rst_n(rst_n),
		.prog_addr_r(prog_addr_r), .prog_rdata(prog_rdata),
		.tbl_wr_start_r(tbl_wr_start_r), .tbl_wr_addr_r(tbl_wr_addr_r),
		.tbl_wr_data_r(tbl_wr_data_r), .io_in(io_in), .io_out_r(io_out_r));
	mie_flash_model u_mie_flash_model (.addr(prog_addr_r),
		.rdata(prog_rdata));
	// Status after negation: {000,N,OV,DC,C,Z}
	function automatic logic [7:0] negf(input logic [7:0] v);
		logic [8:0] q;
		q = {1'b0, ~v} + 9'h001;
		return {3'h0, q[7], q[7:0] == 8'h80, v[3:0] == 4'h0, q[8],
			q[7:0] == 8'h00};
	endfunction
	task automatic chk(input logic [23:0] sv, input logic [23:0] xv);
		checks_done++;
		if (sv !== xv) begin
			n_mismatch++;
			$display("[FAIL] %0t seen %h expected %h", $time, sv, xv);
		end
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// Place a word and book the cycles it costs when run
	task automatic e(input logic [14:0] w, input int c);
		u_mie_flash_model.mem[pc] = w;
		pc++;
		cyc += c;
	endtask
	// Table write shows A; its spacing shows the cycle count
	task automatic obs(input logic [7:0] v);
		e({OP_TABLE_WRITE_START, 10'h000}, 1);
		a = v;
		ed.push_back(24'(v));
		ei.push_back(24'({tp, io}));
		eg.push_back(2 * cyc);
		cyc = 0;
	endtask
	task automatic tick;
		@(posedge core_clk);
		#5;
	endtask
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	// Pulse watcher, then hang guard last
	always @(posedge core_clk) begin
		clk_n++;
		if (tbl_wr_start_r === 1'b1 && ed.size() > 0) begin
			g = eg.pop_front();
			chk(24'(tbl_wr_data_r), ed.pop_front());
			chk(24'({tbl_wr_addr_r, io_out_r}), ei.pop_front());
			if (g > 0) chk(24'(clk_n - last_t), 24'(g));
			last_t = clk_n;
		end
		if (clk_n > 3000) begin
			n_mismatch++;
			end_sim;
		end
	end
	// Three programs: zero and 0x80 corners, then fully random
	initial begin
		rst_n = 1'b0;
		io_in = 8'h00;
		void'($urandom(32'h013A7A18));
		for (it = 0; it < 3; it++) begin
			rst_n = 1'b0;
			pc = 0;
			cyc = -100;
			io = 8'h00;
			tp = '0;
			io_in = 8'($urandom());
			x = (it == 0) ? 8'h00 : (it == 1) ? 8'h80 : 8'($urandom());
			nx = 8'(~x + 8'h01);
			e({OP_MOVAK, 2'b0, x}, 1);
			obs(x);
			e({OP_MOVRA, 4'h8, ADR_IO}, 1);
			io = x;
			e({OP_MOVAR, 4'h0, ADR_IO}, 1);
			obs(io_in);
			e({OP_MOVAK, 2'b0, x}, 1);
			e({OP_MOVRA, 4'h8, 6'h10}, 1);
			e({OP_NEG, 4'h8, 6'h10}, 1);
			e({OP_MOVAR, 4'h0, ADR_STATUS}, 1);
			obs(negf(x));
			e({OP_MOVAR, 4'h0, 6'h10}, 1);
			obs(nx);
			for (i = 0; i < 4; i++) begin
				y = (i % 2 == 1 && it != 2) ? nx : 8'($urandom());
				sk = (i % 2 == 1) ? (y == nx) : (i == 0) ? (nx > y) : (nx < y);
				e({OP_MOVAK, 2'b0, y}, 1);
				e({cop[i], (i == 3) ? {2'b0, nx} : 10'h210}, sk ? 2 : 1);
				e({OP_MOVAK, 2'b0, ~y}, sk ? 0 : 1);
				obs(sk ? y : ~y);
			end
			e({OP_MOVAR, 4'h0, ADR_STATUS}, 1);
			obs(negf(x));
			for (i = 0; i < 4; i++) begin
				y = (it == 1) ? 8'h80 : 8'($urandom());
				k = (it == 1) ? 8'h80 : 8'($urandom());
				s = {1'b0, y} + {1'b0, k};
				sk = (i < 2) ? (s[8] ^ i[0]) : ((s[7:0] == 8'h00) ^ i[0]);
				e({OP_MOVAK, 2'b0, y}, 1);
				e({OP_ADDAK, 2'b0, k}, 1);
				e({jop[i], 10'h003}, sk ? 2 : 1);
				e({OP_MOVAK, 10'h05A}, sk ? 0 : 1);
				e({OP_MOVAK, 2'b0, ~s[7:0]}, sk ? 0 : 1);
				obs(sk ? s[7:0] : ~s[7:0]);
			end
			b = 3'($urandom());
			e({OP_BS, 1'b1, b, ADR_IO}, 1);
			e({OP_BC, 1'b1, b + 3'h1, ADR_IO}, 1);
			// Bit ops read the pins, so only the last write sticks
			io = io_in;
			io[b + 3'h1] = 1'b0;
			obs(a);
			// Bit test on the pins: skip when the bit is set
			sk = io_in[b];
			e({OP_MOVAK, 10'h0A5}, 1);
			e({OP_JBS, 1'b0, b, ADR_IO}, sk ? 2 : 1);
			e({OP_MOVAK, 10'h05A}, sk ? 0 : 1);
			obs(sk ? 8'hA5 : 8'h5A);
			e({OP_MOVAK, 10'h0C0}, 1);
			e({OP_MOVRA, 4'h8, ADR_PC}, 2);
			e({OP_MOVAK, 10'h0FF}, 0);
			pc = 'h0C0;
			obs(8'hC0);
			e({OP_LONG_CALL, 10'h000}, 2);
			e(15'h0100, 0);
			rp = pc;
			pc = 'h100;
			e({OP_MOVAK, 2'b0, y}, 1);
			obs(y);
			e({OP_RET, 10'h000}, 2);
			pc = rp;
			e({OP_LONG_JUMP, 10'h000}, 2);
			e(15'h0140, 0);
			pc = 'h140;
			obs(y);
			tp = {5'h1F, 8'($urandom())};
			tw = 15'($urandom());
			u_mie_flash_model.mem[tp] = tw;
			e({OP_MOVAK, 2'b0, tp[7:0]}, 1);
			e({OP_MOVRA, 4'h8, ADR_TPL}, 1);
			e({OP_MOVAK, 5'h00, tp[12:8]}, 1);
			e({OP_MOVRA, 4'h8, ADR_TPH}, 1);
			e({OP_TABLE_READ_TO_BOTH, 4'h8, 6'h11}, 2);
			obs(tw[7:0]);
			e({OP_MOVAR, 4'h0, 6'h11}, 1);
			obs({1'b0, tw[14:8]});
			e({OP_RESET, 10'h000}, 1);
			repeat (8) tick;
			rst_n = 1'b1;
			for (t = 0; t < 900 && ed.size() > 0; t++) tick;
			for (t = 0; t < 40 && prog_addr_r !== PC_RST; t++) tick;
			chk(24'(ed.size()), 24'h000000);
			chk(24'({tbl_wr_addr_r, io_out_r}), 24'h000000);
		end
		end_sim;
	end
endmodule
